// ===== pkg/ppi_pkg.sv
// Purpose: shared constants and types for the parallel io port
// Assumes: 8-bit host bus, three 8-bit ports
// Notes: mode word layout follows the classic three-port interface
package ppi_pkg;
    localparam logic [1:0] SEL_PORT_A = 2'h0;
    localparam logic [1:0] SEL_PORT_B = 2'h1;
    localparam logic [1:0] SEL_PORT_C = 2'h2;
    localparam logic [1:0] SEL_CTRL = 2'h3;
    localparam int FLAG_BIT = 7;
    localparam int GA_MODE_LO = 5;
    localparam int A_DIR_BIT = 4;
    localparam int CH_DIR_BIT = 3;
    localparam int GB_MODE_BIT = 2;
    localparam int B_DIR_BIT = 1;
    localparam int CL_DIR_BIT = 0;
    localparam int BSR_SEL_LO = 1;
    localparam int BSR_VAL_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h9B;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    typedef struct packed {
        logic [1:0] ga_mode;
        logic a_in;
        logic ch_in;
        logic gb_mode;
        logic b_in;
        logic cl_in;
    } mode_cfg_t;
endpackage

// ===== core/parallel_io_port.sv
// Purpose: three-port programmable parallel io, mode 0 data path with bit set/reset
// Assumes: host strobes synchronous to ref_clk; strobed handshake timing is not implemented
// Notes: pins are split into in/out/oe; ports float while configured as inputs, except port A, which mode 2 drives whatever its direction bit
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - 8-bit bidirectional host bus carries port data, control words and bit commands.
// - reset high loads control with 9B and clears the latches; all groups go to mode 0.
// - on reset all port pins become floating inputs and output latches zero.
// - host transfers happen only while the active-low chip select is low.
// - deselected: bus floats, strobes ignored, registers unchanged.
// - read strobe with chip selected drives the selected port onto the bus.
// - host write strobe loads the bus value into port or control register.
// - two port-select inputs steer access to port A, B, C or control.
// - port A and port B directions come from the control word.
// - group A in mode 2 drives port A at all times; port A reads take the pins.
// - port C direction is set as two independent 4-bit halves.
// - mode 1 or 2 takes over the matching port C pins for handshake.
// - host may set or clear one port C bit without touching others.
// - group A is port A plus upper C; group B is port B plus lower C.
// - control word bit 7: 1 defines modes, 0 is a port C bit command.
// - in a bit command, bit 0 gives the new value of the chosen bit.
// - mode 0 outputs are latched; inputs pass to the bus unlatched.
// - port C reads return the pin levels of bits claimed for control signals.
module parallel_io_port
    import ppi_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic chip_sel_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [1:0] port_select,
    input wire logic [DATA_W-1:0] host_data_bus_in,
    output logic [DATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe,
    input wire logic [DATA_W-1:0] port_a_pins_in,
    output logic [DATA_W-1:0] port_a_pins_out,
    output logic [DATA_W-1:0] port_a_pins_oe,
    input wire logic [DATA_W-1:0] port_b_pins_in,
    output logic [DATA_W-1:0] port_b_pins_out,
    output logic [DATA_W-1:0] port_b_pins_oe,
    input wire logic [DATA_W-1:0] port_c_pins_in,
    output logic [DATA_W-1:0] port_c_pins_out,
    output logic [DATA_W-1:0] port_c_pins_oe,
    output logic [1:0] group_a_mode,
    output logic group_b_mode
);
    if (DATA_W != 8)
    begin : g_chk
        $error("parallel_io_port serves only 8-bit ports");
    end

    mode_cfg_t cfg_ff;
    logic [7:0] a_latch_ff;
    logic [7:0] b_latch_ff;
    logic [7:0] c_latch_ff;
    logic wr_seen_ff;
    logic [7:0] rd_data;
    logic rd_oe;
    logic wr_take;
    logic sel;
    logic [7:0] c_ctl_mask;
    logic [7:0] c_read;

    assign sel = !chip_sel_n;
    // one commit on the first sampled cycle of each low strobe
    assign wr_take = sel && !wr_n && !wr_seen_ff;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            wr_seen_ff <= 1'h0;
        else
            wr_seen_ff <= sel && !wr_n;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            cfg_ff <= mode_cfg_t'(7'(CTRL_RESET));
        else if (wr_take && port_select == SEL_CTRL && host_data_bus_in[FLAG_BIT])
            cfg_ff <= mode_cfg_t'(host_data_bus_in[6:0]);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            a_latch_ff <= LATCH_RESET;
            b_latch_ff <= LATCH_RESET;
        end
        else if (wr_take && port_select == SEL_CTRL && host_data_bus_in[FLAG_BIT])
        begin
            // a mode word clears the output latches
            a_latch_ff <= LATCH_RESET;
            b_latch_ff <= LATCH_RESET;
        end
        else if (wr_take && port_select == SEL_PORT_A)
            a_latch_ff <= host_data_bus_in;
        else if (wr_take && port_select == SEL_PORT_B)
            b_latch_ff <= host_data_bus_in;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            c_latch_ff <= LATCH_RESET;
        else if (wr_take && port_select == SEL_CTRL && host_data_bus_in[FLAG_BIT])
            c_latch_ff <= LATCH_RESET;
        else if (wr_take && port_select == SEL_CTRL)
            c_latch_ff[host_data_bus_in[3:BSR_SEL_LO]] <= host_data_bus_in[BSR_VAL_BIT];
        else if (wr_take && port_select == SEL_PORT_C)
            c_latch_ff <= host_data_bus_in;
    end

    // port C pins claimed as handshake lines by strobed modes
    always_comb
    begin
        c_ctl_mask = 8'h00;
        if (cfg_ff.ga_mode[1])
            c_ctl_mask = c_ctl_mask | 8'hF8;
        else if (cfg_ff.ga_mode[0])
            c_ctl_mask = c_ctl_mask | (cfg_ff.a_in ? 8'h38 : 8'hC8);
        if (cfg_ff.gb_mode)
            c_ctl_mask = c_ctl_mask | 8'h07;
    end

    // handshake lines are not generated here; reads show the pin level of claimed bits
    always_comb
    begin
        c_read = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (c_ctl_mask[i])
                c_read[i] = port_c_pins_in[i];
            else if ((i >= 4) ? cfg_ff.ch_in : cfg_ff.cl_in)
                c_read[i] = port_c_pins_in[i];
            else
                c_read[i] = c_latch_ff[i];
        end
    end

    always_comb
    begin
        rd_data = 8'h00;
        rd_oe = 1'h0;
        if (sel && !rd_n)
        begin
            case (port_select)
                SEL_PORT_A:
                begin
                    rd_data = (cfg_ff.a_in || cfg_ff.ga_mode[1]) ? port_a_pins_in : a_latch_ff;
                    rd_oe = 1'h1;
                end
                SEL_PORT_B:
                begin
                    rd_data = cfg_ff.b_in ? port_b_pins_in : b_latch_ff;
                    rd_oe = 1'h1;
                end
                SEL_PORT_C:
                begin
                    rd_data = c_read;
                    rd_oe = 1'h1;
                end
                default:
                begin
                    rd_data = 8'h00;
                    rd_oe = 1'h0;
                end
            endcase
        end
    end

    assign host_data_bus_out = rd_data;
    assign host_data_bus_oe = rd_oe;

    // mode 2 port A drives its latch at all times; with no handshake logic a read takes the pins
    assign port_a_pins_out = a_latch_ff;
    assign port_a_pins_oe = (cfg_ff.ga_mode[1] || !cfg_ff.a_in) ? 8'hFF : 8'h00;
    assign port_b_pins_out = b_latch_ff;
    assign port_b_pins_oe = cfg_ff.b_in ? 8'h00 : 8'hFF;
    assign port_c_pins_out = c_latch_ff;
    assign port_c_pins_oe = ~c_ctl_mask & {{4{!cfg_ff.ch_in}}, {4{!cfg_ff.cl_in}}};
    assign group_a_mode = cfg_ff.ga_mode;
    assign group_b_mode = cfg_ff.gb_mode;

    a_reset_floats: assert property (@(posedge ref_clk)
        reset |=> (port_a_pins_oe == 8'h00 && port_b_pins_oe == 8'h00 && port_c_pins_oe == 8'h00))
        else $error("ports not floating after reset");

    a_reset_mode0: assert property (@(posedge ref_clk)
        reset |=> (group_a_mode == 2'h0 && !group_b_mode && c_latch_ff == 8'h00))
        else $error("reset did not return mode 0");

    a_desel_float: assert property (@(posedge ref_clk) disable iff (reset)
        chip_sel_n |-> !host_data_bus_oe)
        else $error("bus driven while deselected");

    a_desel_hold: assert property (@(posedge ref_clk) disable iff (reset)
        chip_sel_n |=> $stable(cfg_ff) && $stable(a_latch_ff) && $stable(b_latch_ff) && $stable(c_latch_ff))
        else $error("register changed while deselected");

    a_desel_strobe: assert property (@(posedge ref_clk) disable iff (reset)
        chip_sel_n |-> !wr_take)
        else $error("strobe taken while deselected");

    a_ctrl_read_float: assert property (@(posedge ref_clk) disable iff (reset)
        (port_select == SEL_CTRL) |-> !host_data_bus_oe)
        else $error("control read drove bus");

    a_read_drive: assert property (@(posedge ref_clk) disable iff (reset)
        (!chip_sel_n && !rd_n && port_select != SEL_CTRL) |-> host_data_bus_oe)
        else $error("read did not drive bus");

    a_read_a_pins: assert property (@(posedge ref_clk) disable iff (reset)
        (host_data_bus_oe && port_select == SEL_PORT_A && cfg_ff.a_in && cfg_ff.ga_mode == 2'h0)
            |-> host_data_bus_out == port_a_pins_in)
        else $error("port A input read not from pins");

    a_read_a_latch: assert property (@(posedge ref_clk) disable iff (reset)
        (host_data_bus_oe && port_select == SEL_PORT_A && !cfg_ff.a_in && cfg_ff.ga_mode == 2'h0)
            |-> host_data_bus_out == a_latch_ff)
        else $error("port A output read not from latch");

    a_read_b_pins: assert property (@(posedge ref_clk) disable iff (reset)
        (host_data_bus_oe && port_select == SEL_PORT_B && cfg_ff.b_in) |-> host_data_bus_out == port_b_pins_in)
        else $error("port B input read not from pins");

    // handshake lines are not generated, so claimed port C bits read back as released pins
    a_ctl_read_pins: assert property (@(posedge ref_clk) disable iff (reset)
        (host_data_bus_oe && port_select == SEL_PORT_C && cfg_ff.ga_mode[1])
            |-> host_data_bus_out[7:3] == port_c_pins_in[7:3])
        else $error("control lines not read back");

    a_write_porta: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take && port_select == SEL_PORT_A) |=> a_latch_ff == $past(host_data_bus_in))
        else $error("port A write lost");

    a_write_portb: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take && port_select == SEL_PORT_B) |=> b_latch_ff == $past(host_data_bus_in))
        else $error("port B write lost");

    a_write_portc: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take && port_select == SEL_PORT_C) |=> c_latch_ff == $past(host_data_bus_in))
        else $error("port C write lost");

    a_write_once: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take ##1 (!chip_sel_n && !wr_n)) |-> !wr_take)
        else $error("write committed twice");

    a_bit_cmd: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take && port_select == SEL_CTRL && !host_data_bus_in[FLAG_BIT])
            |=> (c_latch_ff[$past(host_data_bus_in[3:1])] == $past(host_data_bus_in[0])) && $stable(cfg_ff))
        else $error("bit command wrong");

    a_bit_keep: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take && port_select == SEL_CTRL && !host_data_bus_in[FLAG_BIT])
            |=> ((c_latch_ff ^ $past(c_latch_ff)) & ~(8'h01 << $past(host_data_bus_in[3:1]))) == 8'h00)
        else $error("bit command disturbed other bits");

    a_mode_word: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take && port_select == SEL_CTRL && host_data_bus_in[7])
            |=> port_b_pins_oe == ($past(host_data_bus_in[1]) ? 8'h00 : 8'hFF))
        else $error("port B direction not set");

    a_mode_porta_dir: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take && port_select == SEL_CTRL && host_data_bus_in[FLAG_BIT])
            |=> port_a_pins_oe
                == (($past(host_data_bus_in[6]) || !$past(host_data_bus_in[A_DIR_BIT])) ? 8'hFF : 8'h00))
        else $error("port A direction not set");

    a_mode_clears: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_take && port_select == SEL_CTRL && host_data_bus_in[FLAG_BIT])
            |=> (a_latch_ff == LATCH_RESET && b_latch_ff == LATCH_RESET && c_latch_ff == LATCH_RESET))
        else $error("mode word left latches set");

    a_c_hi_dir: assert property (@(posedge ref_clk) disable iff (reset)
        (cfg_ff.ga_mode == 2'h0) |-> port_c_pins_oe[7:4] == {4{!cfg_ff.ch_in}})
        else $error("upper port C half direction wrong");

    a_c_lo_dir: assert property (@(posedge ref_clk) disable iff (reset)
        !cfg_ff.gb_mode |-> port_c_pins_oe[2:0] == {3{!cfg_ff.cl_in}})
        else $error("lower port C half direction wrong");

    a_mode2_claims: assert property (@(posedge ref_clk) disable iff (reset)
        cfg_ff.ga_mode[1] |-> port_c_pins_oe[7:3] == 5'h00)
        else $error("mode 2 control lines driven as data");

    a_mode1_b_claims: assert property (@(posedge ref_clk) disable iff (reset)
        cfg_ff.gb_mode |-> port_c_pins_oe[2:0] == 3'h0)
        else $error("group B control lines driven as data");

    a_mode2_bidir: assert property (@(posedge ref_clk) disable iff (reset)
        cfg_ff.ga_mode[1] |-> port_a_pins_oe == 8'hFF)
        else $error("mode 2 port A not driven");

    c_mode_write: cover property (@(posedge ref_clk) wr_take && port_select == SEL_CTRL && host_data_bus_in[7]);
    c_bit_set: cover property (@(posedge ref_clk)
        wr_take && port_select == SEL_CTRL && !host_data_bus_in[7] && host_data_bus_in[0]);
    c_read_c: cover property (@(posedge ref_clk) host_data_bus_oe && port_select == SEL_PORT_C);
    c_mode2: cover property (@(posedge ref_clk) group_a_mode[1]);
    c_ctl_read: cover property (@(posedge ref_clk) host_data_bus_oe && port_select == SEL_PORT_C && group_a_mode[1]);
endmodule // parallel_io_port

`default_nettype wire

// ===== dv/pin_side_model.sv
// Purpose: far side of the three ports, the logic that the pins face
// Assumes: outside logic drives a level only where the port does not
// Notes: driven bits read back the port's own latch
`timescale 1ns/1ps
`default_nettype none
module pin_side_model
(
    input wire logic [7:0] drv,
    input wire logic [7:0] oe,
    input wire logic [7:0] ext,
    output logic [7:0] lvl
);
    assign lvl = (drv & oe) | (ext & ~oe);
endmodule // pin_side_model
`default_nettype wire

// ===== dv/tb_parallel_io_port.sv
// Purpose: self-checking bench for the parallel io port
// Assumes: host strobes change just after ref_clk rising edges
// Notes: a monitor checks each read against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_io_port;
    import ppi_pkg::*;
    logic ref_clk = 1'h0, reset = 1'h1, chip_sel_n = 1'h1, rd_n = 1'h1, wr_n = 1'h1, doe, gb;
    logic [1:0] port_select = 2'h0, ga;
    logic [7:0] wdat = 8'h00, dout, la, lb, lc, v, m, ext_a, ext_b, ext_c;
    logic [7:0] a_o, a_e, a_i, b_o, b_e, b_i, c_o, c_e, c_i;
    logic [8:0] expq[$];
    int error_cnt = 0, num_checks = 0, seed = 32'hA05C;
    parallel_io_port parallel_io_port_inst (.ref_clk(ref_clk), .reset(reset), .chip_sel_n(chip_sel_n),
        .rd_n(rd_n), .wr_n(wr_n), .port_select(port_select), .host_data_bus_in(wdat),
        .host_data_bus_out(dout), .host_data_bus_oe(doe), .port_a_pins_in(a_i), .port_a_pins_out(a_o),
        .port_a_pins_oe(a_e), .port_b_pins_in(b_i), .port_b_pins_out(b_o), .port_b_pins_oe(b_e),
        .port_c_pins_in(c_i), .port_c_pins_out(c_o), .port_c_pins_oe(c_e), .group_a_mode(ga),
        .group_b_mode(gb));
    pin_side_model pin_a (.drv(a_o), .oe(a_e), .ext(ext_a), .lvl(a_i));
    pin_side_model pin_b (.drv(b_o), .oe(b_e), .ext(ext_b), .lvl(b_i));
    pin_side_model pin_c (.drv(c_o), .oe(c_e), .ext(ext_c), .lvl(c_i));
    initial
        forever #10 ref_clk = ~ref_clk;
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // a held strobe with n > 0 alters the data after the taking edge
    task automatic wr(input logic cs_n, input logic [1:0] s, input logic [7:0] d, input int n);
        @(posedge ref_clk);
        chip_sel_n <= cs_n;
        wr_n <= 1'h0;
        port_select <= s;
        wdat <= d;
        @(posedge ref_clk);
        repeat (n) @(posedge ref_clk) wdat <= ~d;
        chip_sel_n <= 1'h1;
        wr_n <= 1'h1;
    endtask
    task automatic rd(input logic cs_n, input logic [1:0] s, input logic [8:0] e);
        expq.push_back(e);
        @(posedge ref_clk);
        chip_sel_n <= cs_n;
        rd_n <= 1'h0;
        port_select <= s;
        @(posedge ref_clk);
        chip_sel_n <= 1'h1;
        rd_n <= 1'h1;
    endtask
    task automatic pins(input logic [23:0] lat, input logic [23:0] oe);
        repeat (2) @(negedge ref_clk);
        cmp({a_o, b_o, c_o}, lat);
        cmp({a_e, b_e, c_e}, oe);
    endtask
    always @(negedge ref_clk)
        if (!rd_n && !reset)
        begin
            if (expq.size() == 0)
                cmp(24'h1, 24'h0);
            else
                cmp({15'h0, doe, doe ? dout : 8'h00}, {15'h0, expq.pop_front()});
        end
    initial
    begin
        ext_a = 8'($random(seed));
        ext_b = 8'($random(seed));
        ext_c = 8'($random(seed));
        repeat (16) @(posedge ref_clk);
        reset <= 1'h0;
        pins(24'h0, 24'h0);
        cmp({21'h0, ga, gb}, 24'h0);
        rd(1'h0, SEL_PORT_B, {1'h1, ext_b});
        wr(1'h0, SEL_CTRL, 8'h80, 0);
        la = 8'($random(seed));
        lb = 8'($random(seed));
        lc = 8'($random(seed));
        wr(1'h0, SEL_PORT_A, la, 0);
        wr(1'h0, SEL_PORT_B, lb, 0);
        wr(1'h0, SEL_PORT_C, lc, 0);
        pins({la, lb, lc}, 24'hFFFFFF);
        rd(1'h0, SEL_PORT_C, {1'h1, lc});
        rd(1'h0, SEL_CTRL, 9'h000);
        wr(1'h1, SEL_PORT_A, ~la, 0);
        rd(1'h1, SEL_PORT_A, 9'h000);
        wr(1'h0, SEL_PORT_B, 8'h3C, 3);
        pins({la, 8'h3C, lc}, 24'hFFFFFF);
        $display("test access done");
        for (int i = 0; i < 16; i++)
        begin
            wr(1'h0, SEL_CTRL, {4'h0, i[2:0], i[3] ^ i[0]}, 0);
            lc[i[2:0]] = i[3] ^ i[0];
            pins({la, 8'h3C, lc}, 24'hFFFFFF);
        end
        $display("test bit commands done");
        for (int i = 0; i < 16; i++)
        begin
            v = {3'h4, i[3], i[2], 1'b0, i[1], i[0]};
            wr(1'h0, SEL_CTRL, v, 0);
            pins(24'h0, {{8{~v[4]}}, {8{~v[1]}}, {4{~v[3]}}, {4{~v[0]}}});
            rd(1'h0, SEL_PORT_C, {1'h1, ext_c & {{4{v[3]}}, {4{v[0]}}}});
            rd(1'h0, SEL_PORT_A, {1'h1, ext_a & {8{v[4]}}});
        end
        for (int i = 0; i < 8; i++)
            if (i[1:0] != 2'h3)
            begin
                // pins that a strobed mode claims as handshake lines, with port A as output
                m = (i[1] ? 8'hF8 : (i[0] ? 8'hC8 : 8'h00)) | (i[2] ? 8'h07 : 8'h00);
                wr(1'h0, SEL_CTRL, {1'h1, i[1:0], 2'h0, i[2], 2'h0}, 0);
                repeat (2) @(negedge ref_clk);
                cmp({21'h0, ga, gb}, {21'h0, i[1:0], i[2]});
                pins(24'h0, {16'hFFFF, ~m});
                rd(1'h0, SEL_PORT_C, {1'h1, ext_c & m});
            end
        wr(1'h0, SEL_CTRL, 8'hD0, 0);
        repeat (2) @(negedge ref_clk);
        cmp({16'h0, a_e}, 24'h0000FF);
        $display("test modes done");
        wr(1'h0, SEL_PORT_A, 8'hA5, 0);
        @(posedge ref_clk);
        reset <= 1'h1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'h0;
        pins(24'h0, 24'h0);
        cmp({21'h0, ga, gb}, 24'h0);
        $display("test reset again done");
        close_out();
    end
endmodule // tb_parallel_io_port
`default_nettype wire
